// [logic/stcr_regs.sv]
/*
 * stcr_regs: timing and configuration register bank of the voltage
 * supervisor, with fuse override, reset qualification and decoded
 * durations.
 * Assumes a serial front end that delivers byte reads and writes as
 * one-cycle strobes, and a fuse array that presents its settings.
 */
// What this block does
// [R1] Bits 2..0 at 0x07 set monitor-one fault shutdown hold; zero is 200 ms.
// [R2] Bits 2..0 at 0x08 set monitor-one fault shutdown delay; zero is 1200 ms.
// [R3] Bits 2..0 at 0x09 set monitor-two turn-on shutdown hold; zero is 10 ms.
// [R4] Bits 2..0 at 0x0A set monitor-two turn-off shutdown delay; zero 100 ms.
// [R5] Bits 2..0 at 0x0B set reset hold after a reset ends; zero is 200 ms.
// [R6] Bits 2..0 at 0x0C set the watchdog timeout; zero is 1500 ms.
// [R7] Reset config bit 0 low: shutdown also asserts reset; high: it does not.
// [R8] Reset config bit 2 high blocks monitor-four crossings from causing reset.
// [R9] Reset config bit 3 high lets a floating watchdog input cause reset.
// [R10] Rail select bit 3 picks monitor-one rail or regulated rail for shutdown.
// [R11] Watchdog mode bit 3 picks standard or advanced mode.
// [R12] Lock bit 3 high disables all further fuse programming.
// [R13] Special bits 0 and 1 are two fuse programming enables, volatile and never fused.
// [R14] Special bit 2 high forces the shutdown output under software control.
// [R15] Special bit 3 high lets register values override fuse settings.
// [R16] Reserved bits read zero; non-zero codes map through a duration table.
`timescale 1ns/1ps
module stcr_regs #(
	parameter int CYCLES_PER_MS = stcr_pkg::CYCLES_PER_MS // ms divider
) (
	input wire logic clk, // system clock, 250 MHz
	input wire logic reset_n, // async reset, active low
	input wire logic [7:0] reg_addr, // register offset
	input wire logic reg_wr_en, // write strobe, one cycle
	input wire logic [7:0] reg_wr_data, // write byte
	input wire logic reg_rd_en, // read strobe, one cycle
	output logic [7:0] reg_rd_data, // read byte, valid after strobe
	output logic reg_rd_valid, // read byte valid, one cycle
	input wire logic [2:0] fuse_mon1_hold, // fused code
	input wire logic [2:0] fuse_mon1_delay, // fused code
	input wire logic [2:0] fuse_mon2_hold, // fused code
	input wire logic [2:0] fuse_mon2_delay, // fused code
	input wire logic [2:0] fuse_reset_hold, // fused code
	input wire logic [2:0] fuse_wd_timeout, // fused code
	input wire logic [7:0] fuse_reset_cfg, // fused reset config
	input wire logic fuse_rail_vreg, // fused rail select
	input wire logic fuse_wd_advanced, // fused watchdog mode
	input wire logic fuse_prog_locked, // fused programming lock
	input wire logic shutdown_active, // shutdown output asserted
	input wire logic mon4_crossed, // monitor four crossed threshold
	input wire logic wdi_floating, // watchdog input floats
	output logic [15:0] mon1_hold_ms, // monitor one hold time
	output logic [15:0] mon1_delay_ms, // monitor one delay time
	output logic [15:0] mon2_hold_ms, // monitor two hold time
	output logic [15:0] mon2_delay_ms, // monitor two delay time
	output logic [15:0] reset_hold_ms, // reset hold time
	output logic [15:0] wd_timeout_ms, // watchdog timeout
	output logic ms_tick, // one-cycle pulse each millisecond
	output logic shutdown_rail_vreg, // shutdown on regulated rail
	output logic watchdog_advanced, // watchdog in advanced mode
	output logic fuse_prog_enable_a, // fuse programming enable a
	output logic fuse_prog_enable_b, // fuse programming enable b
	output logic shutdown_force, // software forced shutdown
	output logic override_active, // registers override fuses
	output logic reset_request // qualified reset request
);
	import stcr_pkg::*;

	// ----------------------------------------------------------------
	// storage
	// ----------------------------------------------------------------
	logic [2:0] mon1_fault_shutdown_hold;
	logic [2:0] mon1_fault_shutdown_delay;
	logic [2:0] mon2_turn_on_shutdown_hold;
	logic [2:0] mon2_turn_off_shutdown_delay;
	logic [2:0] reset_hold_time;
	logic [2:0] watchdog_timeout;
	logic [7:0] reset_behaviour_config;
	logic shutdown_rail_select;
	logic watchdog_mode_select;
	logic programming_lock;
	logic [3:0] special_functions_one;
	logic [17:0] ms_count;

	// ----------------------------------------------------------------
	// address decode
	// ----------------------------------------------------------------
	logic hit_m1h;
	logic hit_m1d;
	logic hit_m2h;
	logic hit_m2d;
	logic hit_rh;
	logic hit_wdt;
	logic hit_cfg;
	logic hit_rail;
	logic hit_wdm;
	logic hit_lock;
	logic hit_sf;
	logic [7:0] cfg_mask;

	assign hit_m1h = reg_addr == ADDR_MON1_HOLD;
	assign hit_m1d = reg_addr == ADDR_MON1_DELAY;
	assign hit_m2h = reg_addr == ADDR_MON2_HOLD;
	assign hit_m2d = reg_addr == ADDR_MON2_DELAY;
	assign hit_rh = reg_addr == ADDR_RESET_HOLD;
	assign hit_wdt = reg_addr == ADDR_WD_TIMEOUT;
	assign hit_cfg = reg_addr == ADDR_RESET_CFG;
	assign hit_rail = reg_addr == ADDR_RAIL_SEL;
	assign hit_wdm = reg_addr == ADDR_WD_MODE;
	assign hit_lock = reg_addr == ADDR_PROG_LOCK;
	assign hit_sf = reg_addr == ADDR_SPECIAL_ONE;
	// only bits 0, 2 and 3 of the reset config exist
	assign cfg_mask = (8'h01 << CFG_SHUTDOWN_OUTPUT_NO_RESET)
		| (8'h01 << CFG_MON4_BLOCK) | (8'h01 << CFG_WDI_FLOAT);

	// ----------------------------------------------------------------
	// timing code registers
	// ----------------------------------------------------------------
	// each code keeps bits 2..0; upper write bits are dropped
	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
			mon1_fault_shutdown_hold <= CODE_RESET;
		else if (reg_wr_en && hit_m1h)
			mon1_fault_shutdown_hold <= reg_wr_data[2:0]; // see [R1]
	end

	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
			mon1_fault_shutdown_delay <= CODE_RESET;
		else if (reg_wr_en && hit_m1d)
			mon1_fault_shutdown_delay <= reg_wr_data[2:0]; // see [R2]
	end

	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
			mon2_turn_on_shutdown_hold <= CODE_RESET;
		else if (reg_wr_en && hit_m2h)
			mon2_turn_on_shutdown_hold <= reg_wr_data[2:0]; // see [R3]
	end

	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
			mon2_turn_off_shutdown_delay <= CODE_RESET;
		else if (reg_wr_en && hit_m2d)
			mon2_turn_off_shutdown_delay <= reg_wr_data[2:0]; // see [R4]
	end

	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
			reset_hold_time <= CODE_RESET;
		else if (reg_wr_en && hit_rh)
			reset_hold_time <= reg_wr_data[2:0]; // see [R5]
	end

	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
			watchdog_timeout <= CODE_RESET;
		else if (reg_wr_en && hit_wdt)
			watchdog_timeout <= reg_wr_data[2:0]; // see [R6]
	end

	// ----------------------------------------------------------------
	// configuration registers
	// ----------------------------------------------------------------
	// reserved config bit positions are masked off on write
	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
			reset_behaviour_config <= REG_RESET;
		else if (reg_wr_en && hit_cfg)
			reset_behaviour_config <= reg_wr_data & cfg_mask; // see [R16]
	end

	// single-bit selects keep only bit 3
	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			shutdown_rail_select <= 1'b0;
			watchdog_mode_select <= 1'b0;
			programming_lock <= 1'b0;
		end
		else if (reg_wr_en)
		begin
			if (hit_rail)
				shutdown_rail_select <= reg_wr_data[RAIL_VREG_BIT];
			if (hit_wdm)
				watchdog_mode_select <= reg_wr_data[WD_ADVANCED_BIT];
			if (hit_lock)
				programming_lock <= reg_wr_data[LOCK_BIT];
		end
	end

	// special functions are volatile and never fused
	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
			special_functions_one <= SF_RESET;
		else if (reg_wr_en && hit_sf)
			special_functions_one <= reg_wr_data[SF_W-1:0]; // see [R13]
	end

	// ----------------------------------------------------------------
	// read path
	// ----------------------------------------------------------------
	logic [7:0] rd_word;

	// and-or mux; unmapped offsets and reserved bits give zero
	assign rd_word = ({8{hit_m1h}} & {5'h00, mon1_fault_shutdown_hold})
		| ({8{hit_m1d}} & {5'h00, mon1_fault_shutdown_delay})
		| ({8{hit_m2h}} & {5'h00, mon2_turn_on_shutdown_hold})
		| ({8{hit_m2d}} & {5'h00, mon2_turn_off_shutdown_delay})
		| ({8{hit_rh}} & {5'h00, reset_hold_time})
		| ({8{hit_wdt}} & {5'h00, watchdog_timeout})
		| ({8{hit_cfg}} & reset_behaviour_config)
		| ({8{hit_rail}} & {4'h0, shutdown_rail_select, 3'h0})
		| ({8{hit_wdm}} & {4'h0, watchdog_mode_select, 3'h0})
		| ({8{hit_lock}} & {4'h0, programming_lock, 3'h0})
		| ({8{hit_sf}} & {4'h0, special_functions_one}); // see [R16]

	// read data is captured on the strobe and held until the next one
	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			reg_rd_data <= REG_RESET;
			reg_rd_valid <= 1'b0;
		end
		else
		begin
			reg_rd_valid <= reg_rd_en;
			if (reg_rd_en)
				reg_rd_data <= rd_word;
		end
	end

	// ----------------------------------------------------------------
	// fuse or register selection
	// ----------------------------------------------------------------
	logic ovr;
	logic [2:0] eff_code [NUM_TIMERS];
	logic [7:0] eff_cfg;
	logic eff_rail;
	logic eff_wdm;
	logic lock_now;

	// the override bit hands control from fuses to registers
	assign ovr = special_functions_one[SF_OVERRIDE]; // see [R15]
	assign eff_code[T_MON1_HOLD] = ovr ? mon1_fault_shutdown_hold
		: fuse_mon1_hold;
	assign eff_code[T_MON1_DELAY] = ovr ? mon1_fault_shutdown_delay
		: fuse_mon1_delay;
	assign eff_code[T_MON2_HOLD] = ovr ? mon2_turn_on_shutdown_hold
		: fuse_mon2_hold;
	assign eff_code[T_MON2_DELAY] = ovr ? mon2_turn_off_shutdown_delay
		: fuse_mon2_delay;
	assign eff_code[T_RESET_HOLD] = ovr ? reset_hold_time
		: fuse_reset_hold;
	assign eff_code[T_WD_TIMEOUT] = ovr ? watchdog_timeout
		: fuse_wd_timeout;
	assign eff_cfg = ovr ? reset_behaviour_config
		: (fuse_reset_cfg & cfg_mask);
	assign eff_rail = ovr ? shutdown_rail_select : fuse_rail_vreg;
	assign eff_wdm = ovr ? watchdog_mode_select : fuse_wd_advanced;
	// a blown lock cannot be undone by override, so either one locks
	assign lock_now = programming_lock | fuse_prog_locked; // see [R12]

	// ----------------------------------------------------------------
	// duration decoders
	// ----------------------------------------------------------------
	localparam stcr_ms_type [NUM_TIMERS-1:0] DEFAULTS = {
		WD_TIMEOUT_MS, RESET_HOLD_MS, MON2_DELAY_MS,
		MON2_HOLD_MS, MON1_DELAY_MS, MON1_HOLD_MS};
	logic [15:0] dur_ms [NUM_TIMERS];

	// one decoder per timing field, default on code zero
	generate
		for (genvar i = 0; i < NUM_TIMERS; i++)
		begin : g_dec
			stcr_time_decode #(
				.DEFAULT_MS(DEFAULTS[i])
			) u_dec (
				.clk(clk),
				.reset_n(reset_n),
				.code(eff_code[i]),
				.duration_ms(dur_ms[i])
			); // see [R16]
		end
	endgenerate

	assign mon1_hold_ms = dur_ms[T_MON1_HOLD]; // see [R1]
	assign mon1_delay_ms = dur_ms[T_MON1_DELAY]; // see [R2]
	assign mon2_hold_ms = dur_ms[T_MON2_HOLD]; // see [R3]
	assign mon2_delay_ms = dur_ms[T_MON2_DELAY]; // see [R4]
	assign reset_hold_ms = dur_ms[T_RESET_HOLD]; // see [R5]
	assign wd_timeout_ms = dur_ms[T_WD_TIMEOUT]; // see [R6]

	// ----------------------------------------------------------------
	// millisecond time base
	// ----------------------------------------------------------------
	localparam logic [17:0] MS_LAST = 18'(CYCLES_PER_MS - 1);

	// divider gives the timers one enable pulse per millisecond
	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			ms_count <= 18'h00000;
			ms_tick <= 1'b0;
		end
		else
		begin
			ms_tick <= ms_count == MS_LAST;
			ms_count <= (ms_count == MS_LAST) ? 18'h00000
				: ms_count + 18'h00001;
		end
	end

	// ----------------------------------------------------------------
	// qualified controls
	// ----------------------------------------------------------------
	logic next_reset_request;
	logic next_prog_a;
	logic next_prog_b;

	// reset sources gated by the active reset configuration
	assign next_reset_request =
		(shutdown_active & ~eff_cfg[CFG_SHUTDOWN_OUTPUT_NO_RESET]) // see [R7]
		| (mon4_crossed & ~eff_cfg[CFG_MON4_BLOCK]) // see [R8]
		| (wdi_floating & eff_cfg[CFG_WDI_FLOAT]); // see [R9]
	// programming enables only count while not locked
	assign next_prog_a = special_functions_one[SF_OTP_A]
		& ~lock_now; // see [R13]
	assign next_prog_b = special_functions_one[SF_OTP_B]
		& ~lock_now; // see [R13]

	// all control outputs come from flip-flops
	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			reset_request <= 1'b0;
			shutdown_rail_vreg <= 1'b0;
			watchdog_advanced <= 1'b0;
			fuse_prog_enable_a <= 1'b0;
			fuse_prog_enable_b <= 1'b0;
			shutdown_force <= 1'b0;
			override_active <= 1'b0;
		end
		else
		begin
			reset_request <= next_reset_request;
			shutdown_rail_vreg <= eff_rail; // see [R10]
			watchdog_advanced <= eff_wdm; // see [R11]
			fuse_prog_enable_a <= next_prog_a;
			fuse_prog_enable_b <= next_prog_b;
			shutdown_force <= special_functions_one[SF_SW_SHUTDOWN_OUTPUT]; // see [R14]
			override_active <= ovr; // see [R15]
		end
	end

endmodule : stcr_regs

// [common/stcr_pkg.sv]
/*
 * stcr_pkg: shared constants of the supervisor timing and configuration
 * register bank: register offsets, field positions, reset values,
 * duration table and clock figures.
 * Assumes a single 250 MHz clock and byte-wide register access.
 */
package stcr_pkg;

	// ----------------------------------------------------------------
	// register offsets
	// ----------------------------------------------------------------
	localparam logic [7:0] ADDR_MON1_HOLD = 8'h07;
	localparam logic [7:0] ADDR_MON1_DELAY = 8'h08;
	localparam logic [7:0] ADDR_MON2_HOLD = 8'h09;
	localparam logic [7:0] ADDR_MON2_DELAY = 8'h0A;
	localparam logic [7:0] ADDR_RESET_HOLD = 8'h0B;
	localparam logic [7:0] ADDR_WD_TIMEOUT = 8'h0C;
	localparam logic [7:0] ADDR_RESET_CFG = 8'h0D;
	localparam logic [7:0] ADDR_RAIL_SEL = 8'h0E;
	localparam logic [7:0] ADDR_WD_MODE = 8'h0F;
	localparam logic [7:0] ADDR_PROG_LOCK = 8'h15;
	localparam logic [7:0] ADDR_SPECIAL_ONE = 8'h16;

	// ----------------------------------------------------------------
	// field positions and reset values
	// ----------------------------------------------------------------
	localparam int CODE_W = 3;
	localparam int CFG_SHUTDOWN_OUTPUT_NO_RESET = 0;
	localparam int CFG_MON4_BLOCK = 2;
	localparam int CFG_WDI_FLOAT = 3;
	localparam int RAIL_VREG_BIT = 3;
	localparam int WD_ADVANCED_BIT = 3;
	localparam int LOCK_BIT = 3;
	localparam int SF_OTP_A = 0;
	localparam int SF_OTP_B = 1;
	localparam int SF_SW_SHUTDOWN_OUTPUT = 2;
	localparam int SF_OVERRIDE = 3;
	localparam int SF_W = 4;
	localparam logic [7:0] REG_RESET = 8'h00;
	localparam logic [2:0] CODE_RESET = 3'h0;
	localparam logic [3:0] SF_RESET = 4'h0;

	// ----------------------------------------------------------------
	// durations, in milliseconds
	// ----------------------------------------------------------------
	typedef logic [15:0] stcr_ms_type;
	localparam int NUM_TIMERS = 6;
	localparam int T_MON1_HOLD = 0;
	localparam int T_MON1_DELAY = 1;
	localparam int T_MON2_HOLD = 2;
	localparam int T_MON2_DELAY = 3;
	localparam int T_RESET_HOLD = 4;
	localparam int T_WD_TIMEOUT = 5;
	localparam stcr_ms_type MON1_HOLD_MS = 16'h00C8; // 200 ms
	localparam stcr_ms_type MON1_DELAY_MS = 16'h04B0; // 1200 ms
	localparam stcr_ms_type MON2_HOLD_MS = 16'h000A; // 10 ms
	localparam stcr_ms_type MON2_DELAY_MS = 16'h0064; // 100 ms
	localparam stcr_ms_type RESET_HOLD_MS = 16'h00C8; // 200 ms
	localparam stcr_ms_type WD_TIMEOUT_MS = 16'h05DC; // 1500 ms
	// durations of codes 1..7, shared by all timing fields
	localparam stcr_ms_type [7:1] STEP_MS = {
		16'h03E8, 16'h01F4, 16'h00C8, 16'h0064,
		16'h0032, 16'h0014, 16'h000A};

	// ----------------------------------------------------------------
	// clock figures
	// ----------------------------------------------------------------
	localparam int CLK_PERIOD_NS = 4;
	localparam int MS_IN_NS = 1000000;
	localparam int CYCLES_PER_MS = MS_IN_NS / CLK_PERIOD_NS;

endpackage : stcr_pkg

// [logic/stcr_time_decode.sv]
/*
 * stcr_time_decode: turns one 3-bit timing code into a duration in
 * milliseconds; code zero gives the field's default.
 * Assumes the code is stable in the clock domain of clk.
 */
`timescale 1ns/1ps
module stcr_time_decode #(
	parameter stcr_pkg::stcr_ms_type DEFAULT_MS = 16'h0001
) (
	input wire logic clk, // system clock
	input wire logic reset_n, // async reset, active low
	input wire logic [2:0] code, // timing code
	output logic [15:0] duration_ms // decoded duration
);
	import stcr_pkg::*;

	logic [15:0] next_duration_ms;

	// code zero keeps the default, others come from the step table
	assign next_duration_ms = (code == CODE_RESET) ? DEFAULT_MS
		: STEP_MS[code];

	// registered result
	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
			duration_ms <= DEFAULT_MS;
		else
			duration_ms <= next_duration_ms;
	end

endmodule : stcr_time_decode

// [testbench/stcr_regs_checker.sv]
/*
 * stcr_regs_checker: port assertions of the timing and config bank.
 * Assumes it is bound to stcr_regs and sees only that module's ports.
 */
`timescale 1ns/1ps
module stcr_regs_checker (
	input wire logic clk, // system clock
	input wire logic reset_n, // async reset, active low
	input wire logic [7:0] reg_addr, // register offset
	input wire logic reg_wr_en, // write strobe
	input wire logic [7:0] reg_wr_data, // write byte
	input wire logic reg_rd_en, // read strobe
	input wire logic [7:0] reg_rd_data, // read byte
	input wire logic reg_rd_valid, // read byte valid
	input wire logic [2:0] fuse_mon1_hold, // fused code
	input wire logic [2:0] fuse_wd_timeout, // fused code
	input wire logic [7:0] fuse_reset_cfg, // fused reset config
	input wire logic fuse_rail_vreg, // fused rail select
	input wire logic fuse_wd_advanced, // fused watchdog mode
	input wire logic fuse_prog_locked, // fused lock
	input wire logic shutdown_active, // reset source
	input wire logic mon4_crossed, // reset source
	input wire logic wdi_floating, // reset source
	input wire logic [15:0] mon1_hold_ms, // hold time
	input wire logic [15:0] wd_timeout_ms, // watchdog timeout
	input wire logic shutdown_rail_vreg, // rail select out
	input wire logic watchdog_advanced, // mode out
	input wire logic fuse_prog_enable_a, // enable a
	input wire logic fuse_prog_enable_b, // enable b
	input wire logic shutdown_force, // forced shutdown
	input wire logic override_active, // override out
	input wire logic reset_request // reset request
);
	import stcr_pkg::*;
	logic unmapped;
	logic fuse_req;
	default clocking cb @(posedge clk); endclocking
	default disable iff (!reset_n);
	// address decode and fused reset request, for comparison
	assign unmapped = !(reg_addr inside {[8'h07:8'h0F], 8'h15, 8'h16});
	assign fuse_req = shutdown_active & ~fuse_reset_cfg[0]
		| mon4_crossed & ~fuse_reset_cfg[2]
		| wdi_floating & fuse_reset_cfg[3];
	// steps of a special function write and of the fuse path
	sequence sf_write(int b);
		reg_wr_en && reg_addr == ADDR_SPECIAL_ONE && reg_wr_data[b];
	endsequence
	sequence sf_kept;
		!(reg_wr_en && reg_addr == ADDR_SPECIAL_ONE);
	endsequence
	sequence on_fuses;
		##1 !override_active;
	endsequence
	unmapped_read_a: assert property (
		reg_rd_en && unmapped |=> reg_rd_valid && reg_rd_data == 8'h00)
		else $error("unmapped read not zero");
	reserved_bits_a: assert property (
		reg_rd_en && reg_addr inside {[8'h07:8'h0C]}
		|=> reg_rd_valid && reg_rd_data[7:3] == 5'h00)
		else $error("reserved bits read nonzero");
	soft_shutdown_a: assert property (
		sf_write(SF_SW_SHUTDOWN_OUTPUT) ##1 sf_kept |=> shutdown_force)
		else $error("software shutdown not applied");
	prog_lock_a: assert property (
		fuse_prog_locked |=> !fuse_prog_enable_a && !fuse_prog_enable_b)
		else $error("programming enabled while locked");
	reset_sources_a: assert property (
		fuse_req ##0 on_fuses |-> reset_request)
		else $error("reset source ignored");
	reset_quiet_a: assert property (
		!fuse_req ##0 on_fuses |-> !reset_request)
		else $error("reset raised without source");
	rail_follow_a: assert property (
		on_fuses |-> shutdown_rail_vreg == $past(fuse_rail_vreg))
		else $error("rail select wrong");
	wd_mode_a: assert property (
		on_fuses |-> watchdog_advanced == $past(fuse_wd_advanced))
		else $error("watchdog mode wrong");
	default_times_a: assert property (
		fuse_mon1_hold == 3'h0 && fuse_wd_timeout == 3'h0 ##0 on_fuses
		|-> mon1_hold_ms == MON1_HOLD_MS && wd_timeout_ms == WD_TIMEOUT_MS)
		else $error("default duration wrong");
endmodule : stcr_regs_checker

bind stcr_regs stcr_regs_checker u_chk (.clk, .reset_n, .reg_addr,
	.reg_wr_en, .reg_wr_data, .reg_rd_en, .reg_rd_data, .reg_rd_valid,
	.fuse_mon1_hold, .fuse_wd_timeout, .fuse_reset_cfg, .fuse_rail_vreg,
	.fuse_wd_advanced, .fuse_prog_locked, .shutdown_active, .mon4_crossed,
	.wdi_floating, .mon1_hold_ms, .wd_timeout_ms, .shutdown_rail_vreg,
	.watchdog_advanced, .fuse_prog_enable_a, .fuse_prog_enable_b,
	.shutdown_force, .override_active, .reset_request);

// [testbench/stcr_host_model.sv]
/*
 * stcr_host_model: host that reads and writes bytes of the bank.
 * Assumes the byte strobe port of stcr_regs; drives at falling edges.
 */
`timescale 1ns/1ps
module stcr_host_model (
	input wire logic clk, // system clock
	output logic [7:0] reg_addr, // register offset
	output logic reg_wr_en, // write strobe
	output logic [7:0] reg_wr_data, // write byte
	output logic reg_rd_en, // read strobe
	input wire logic [7:0] reg_rd_data, // read byte
	input wire logic reg_rd_valid // read byte valid
);
	// idle bus at time zero
	initial
	begin
		reg_addr = 8'h00;
		reg_wr_en = 1'b0;
		reg_wr_data = 8'h00;
		reg_rd_en = 1'b0;
	end
	// one-cycle write strobe; also how the host sets enables
	task automatic write_byte(input logic [7:0] a, input logic [7:0] d);
		@(negedge clk);
		reg_addr = a;
		reg_wr_data = d;
		reg_wr_en = 1'b1;
		@(negedge clk);
		reg_wr_en = 1'b0;
		reg_addr = ~a; // released lines show a changed pattern
		reg_wr_data = ~d;
	endtask : write_byte
	// one-cycle read strobe, byte taken one cycle later
	task automatic read_byte(input logic [7:0] a, output logic [7:0] d,
		output logic ok);
		@(negedge clk);
		reg_addr = a;
		reg_rd_en = 1'b1;
		@(negedge clk);
		reg_rd_en = 1'b0;
		reg_addr = ~a;
		ok = reg_rd_valid;
		d = reg_rd_data;
	endtask : read_byte
endmodule : stcr_host_model

// [testbench/stcr_regs_test.sv]
/*
 * stcr_regs_test: self-checking bench of the timing and config bank.
 * Assumes stcr_regs, the host model and the bound checker.
 */
`timescale 1ns/1ps
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin \
	num_errors++; \
	$display("[FAIL] %0t got %0h expected %0h", $time, g, e); end end
module stcr_regs_test;
	import stcr_pkg::*;
	logic clk = 1'b0;
	logic reset_n = 1'b0;
	logic [7:0] reg_addr, reg_wr_data, reg_rd_data, fuse_reset_cfg;
	logic reg_wr_en, reg_rd_en, reg_rd_valid, fuse_rail_vreg;
	logic fuse_wd_advanced, fuse_prog_locked, shutdown_active;
	logic mon4_crossed, wdi_floating, ms_tick, shutdown_rail_vreg;
	logic watchdog_advanced, fuse_prog_enable_a, fuse_prog_enable_b;
	logic shutdown_force, override_active, reset_request;
	logic [2:0] fuse_mon1_hold, fuse_mon1_delay, fuse_mon2_hold;
	logic [2:0] fuse_mon2_delay, fuse_reset_hold, fuse_wd_timeout;
	logic [15:0] mon1_hold_ms, mon1_delay_ms, mon2_hold_ms;
	logic [15:0] mon2_delay_ms, reset_hold_ms, wd_timeout_ms;
	int num_errors = 0;
	int tests_run = 0;
	int cycles = 0;
	logic [15:0] dflt [6] = '{MON1_HOLD_MS, MON1_DELAY_MS, MON2_HOLD_MS,
		MON2_DELAY_MS, RESET_HOLD_MS, WD_TIMEOUT_MS};
	logic [7:0] addrs [11] = '{ADDR_MON1_HOLD, ADDR_MON1_DELAY,
		ADDR_MON2_HOLD, ADDR_MON2_DELAY, ADDR_RESET_HOLD, ADDR_WD_TIMEOUT,
		ADDR_RESET_CFG, ADDR_RAIL_SEL, ADDR_WD_MODE, ADDR_PROG_LOCK,
		ADDR_SPECIAL_ONE};
	logic [7:0] masks [11] = '{8'h07, 8'h07, 8'h07, 8'h07, 8'h07, 8'h07,
		8'h0D, 8'h08, 8'h08, 8'h08, 8'h0F};

	// short millisecond divider keeps the tick visible
	stcr_regs #(.CYCLES_PER_MS(8)) i_dut (.*);
	stcr_host_model i_host (.clk, .reg_addr, .reg_wr_en, .reg_wr_data,
		.reg_rd_en, .reg_rd_data, .reg_rd_valid);

	// clock and hang limit
	always #2 clk = ~clk;
	always @(posedge clk)
	begin
		cycles++;
		if (cycles == 3000)
		begin
			num_errors++;
			give_verdict();
		end
	end

	// ------------------------------------------------------------
	// tasks
	// ------------------------------------------------------------
	task automatic rd(input logic [7:0] a, input logic [7:0] e);
		logic [7:0] d;
		logic ok;
		i_host.read_byte(a, d, ok);
		`CHK(ok, 1'b1)
		`CHK(d, e)
	endtask : rd
	task automatic settle();
		repeat (3) @(negedge clk);
	endtask : settle
	task automatic fuses(input logic [2:0] c);
		{fuse_mon1_hold, fuse_mon1_delay, fuse_mon2_hold} = {3{c}};
		{fuse_mon2_delay, fuse_reset_hold, fuse_wd_timeout} = {3{c}};
	endtask : fuses
	task automatic chk_times(input int k);
		logic [15:0] g [6];
		g = '{mon1_hold_ms, mon1_delay_ms, mon2_hold_ms, mon2_delay_ms,
			reset_hold_ms, wd_timeout_ms};
		for (int i = 0; i < 6; i++)
			`CHK(g[i], (k == 0) ? dflt[i] : STEP_MS[k])
	endtask : chk_times
	task give_verdict();
		$display("comparisons %0d mismatches %0d", tests_run, num_errors);
		if (num_errors == 0 && tests_run > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask : give_verdict

	// ------------------------------------------------------------
	// main sequence
	// ------------------------------------------------------------
	initial
	begin
		fuses(3'h0);
		fuse_reset_cfg = 8'h00;
		{fuse_rail_vreg, fuse_wd_advanced, fuse_prog_locked} = 3'h0;
		{shutdown_active, mon4_crossed, wdi_floating} = 3'h0;
		repeat (5) @(negedge clk);
		reset_n = 1'b1;
		for (int i = 0; i < 11; i++)
			rd(addrs[i], REG_RESET);
		rd(8'h10, 8'h00);
		$display("reset values done");
		for (int i = 0; i < 11; i++)
		begin
			i_host.write_byte(addrs[i], 8'hFF);
			rd(addrs[i], masks[i]);
		end
		i_host.write_byte(8'h17, 8'hFF);
		rd(8'h17, 8'h00);
		settle();
		`CHK(shutdown_force, 1'b1)
		`CHK(override_active, 1'b1)
		`CHK(fuse_prog_enable_a, 1'b0)
		i_host.write_byte(ADDR_PROG_LOCK, 8'h00);
		settle();
		`CHK({fuse_prog_enable_a, fuse_prog_enable_b}, 2'h3)
		fuse_prog_locked = 1'b1;
		settle();
		`CHK(fuse_prog_enable_b, 1'b0)
		fuse_prog_locked = 1'b0;
		$display("readback done");
		i_host.write_byte(ADDR_SPECIAL_ONE, 8'h00);
		i_host.write_byte(ADDR_RAIL_SEL, 8'h00);
		i_host.write_byte(ADDR_WD_MODE, 8'h00);
		{fuse_rail_vreg, fuse_wd_advanced} = 2'h3;
		for (int k = 0; k < 8; k++)
		begin
			fuses(3'(k));
			settle();
			chk_times(k);
		end
		`CHK({shutdown_rail_vreg, watchdog_advanced}, 2'h3)
		`CHK({shutdown_force, fuse_prog_enable_a}, 2'h0)
		fuses(3'h2);
		i_host.write_byte(ADDR_SPECIAL_ONE, 8'h08);
		settle();
		chk_times(7);
		`CHK({shutdown_rail_vreg, watchdog_advanced}, 2'h0)
		$display("fuse and override done");
		for (int c = 0; c < 2; c++)
		begin
			i_host.write_byte(ADDR_RESET_CFG, (c == 1) ? 8'h0D : 8'h00);
			fuse_reset_cfg = (c == 1) ? 8'h00 : 8'h0D;
			for (int s = 0; s < 3; s++)
			begin
				{wdi_floating, mon4_crossed, shutdown_active} = 3'h1 << s;
				settle();
				`CHK(reset_request, 1'((s == 2) == (c == 1)))
			end
		end
		$display("reset config done");
		give_verdict();
	end
endmodule : stcr_regs_test
